/* File: pkg/cdr_pkg.sv */
package cdr_pkg;

   // Divide ratio from recovered bit clock to reference frequency
   localparam int unsigned REF_DIVIDE      = 64;
   localparam int unsigned DIV_W           = 6;

   // Frequency window: reference edges counted per comparison
   localparam int unsigned WINDOW_REFS     = 2000;
   localparam int unsigned CNT_W           = 12;
   localparam int unsigned PPM_SCALE       = 1000000;
   localparam int unsigned FINE_PPM        = 500;
   localparam int unsigned COARSE_PPM      = 2000;
   localparam logic [11:0] FINE_THRESH     =
      12'(WINDOW_REFS * FINE_PPM / PPM_SCALE);
   localparam logic [11:0] COARSE_THRESH   =
      12'(WINDOW_REFS * COARSE_PPM / PPM_SCALE);
   localparam logic [11:0] WINDOW_LAST     = 12'(WINDOW_REFS - 1);
   localparam logic [11:0] WINDOW_TARGET   = 12'(WINDOW_REFS);
   localparam logic [11:0] CNT_MAX         = 12'hfff;

   // Acquisition time budget, longest time rounds down
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned ACQ_TIME_US     = 500;
   localparam int unsigned ACQ_CYCLES      =
      ACQ_TIME_US * 1000 / CLK_PERIOD_NS;

   // Demultiplexer
   localparam logic [1:0]  LAST_LANE       = 2'h3;
   localparam logic [1:0]  CLK_HIGH_LANES  = 2'h2;

   typedef enum logic [1:0] {
      ACQ_PFD,
      ACQ_BB,
      TRACK
   } loop_mode_e;

   typedef enum logic [1:0] {
      PUMP_HIZ,
      PUMP_SOURCE,
      PUMP_SINK
   } pump_e;

   // Lane zero holds the earliest bit of the group
   typedef struct packed {
      logic parallel_lane_three;
      logic parallel_lane_two;
      logic parallel_lane_one;
      logic parallel_lane_zero;
   } demux_word_s;

   function automatic logic [11:0] abs_diff(input logic [11:0] a,
                                            input logic [11:0] b);
      abs_diff = (a > b) ? 12'(a - b) : 12'(b - a);
   endfunction : abs_diff

endpackage : cdr_pkg

/* File: hw/cdr_word_buffer.sv */
`timescale 1ns/10ps
module cdr_word_buffer
import cdr_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   input  wire logic               clear,
   input  wire logic               in_valid,
   input  cdr_pkg::demux_word_s    in_data,
   output logic                    in_ready,
   output logic                    out_valid,
   input  wire logic               out_ready,
   output cdr_pkg::demux_word_s    out_data
);
   demux_word_s ent0_ff;
   demux_word_s ent1_ff;
   logic        v0_ff;
   logic        v1_ff;
   demux_word_s nxt_ent0;
   demux_word_s nxt_ent1;
   logic        nxt_v0;
   logic        nxt_v1;

   assign in_ready  = ~v1_ff;
   assign out_valid = v0_ff;
   assign out_data  = ent0_ff;

   // Head always sits in entry 0 so the outputs come straight from flops
   always_comb begin
      nxt_ent0 = ent0_ff;
      nxt_ent1 = ent1_ff;
      nxt_v0   = v0_ff;
      nxt_v1   = v1_ff;
      if (v0_ff && out_ready) begin
         nxt_ent0 = ent1_ff;
         nxt_v0   = v1_ff;
         nxt_v1   = 1'b0;
      end
      if (in_valid && !v1_ff) begin
         if (!nxt_v0) begin
            nxt_ent0 = in_data;
            nxt_v0   = 1'b1;
         end else begin
            nxt_ent1 = in_data;
            nxt_v1   = 1'b1;
         end
      end
      if (clear) begin
         nxt_v0 = 1'b0;
         nxt_v1 = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ent0_ff <= '0;
         ent1_ff <= '0;
         v0_ff   <= 1'b0;
         v1_ff   <= 1'b0;
      end else begin
         ent0_ff <= nxt_ent0;
         ent1_ff <= nxt_ent1;
         v0_ff   <= nxt_v0;
         v1_ff   <= nxt_v1;
      end
   end

endmodule : cdr_word_buffer

/* File: hw/cdr_lock_detect_demux.sv */
// Contract
// - Compare reference with divided clock; deviation selects acquisition.
// - Inside lock range, bang-bang detector takes the loop to track data.
// - Frequency detector of set/reset cells, used only in acquisition.
// - Reference runs at 1/64 of bit rate; recovered clock divided by 64.
// - Bang-bang detector samples each bit at boundary and mid-bit.
// - On bit transition, boundary sample decides early or late.
// - Selected detector drives pump: sink, source or high impedance.
// - Lock indicator stays high throughout recovery mode.
// - Acquiring: lock high with bang-bang, low with frequency detector.
// - Acquisition completes within 500 us; lock asserts after acquisition (code raises lock on entering bang-bang acquisition).
// - Recovered bits demultiplexed to four lanes with quarter-rate clock.
// - Output clock always runs from the recovered oscillator, data or not.
// - Operates across 2.3 to 2.7 Gbit/s line rates.
// - Lane zero carries earliest bit of each group, later lanes in order.
// - Global test reset, active high, resets the device; inactive in use.
`timescale 1ns/10ps
module cdr_lock_detect_demux
import cdr_pkg::*;
#(
   parameter int unsigned ACQ_LIMIT = cdr_pkg::ACQ_CYCLES
)
(
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   input  wire logic               global_test_reset,
   input  wire logic               threshold_coarse,
   input  wire logic               reference_clock_in,
   input  wire logic               vco_bit_tick,
   input  wire logic               serial_in_pos,
   input  wire logic               serial_in_neg,
   input  wire logic               boundary_in_pos,
   input  wire logic               boundary_in_neg,
   input  wire logic               lane_ready,
   output logic                    lock_indicator,
   output cdr_pkg::pump_e          pump_cmd,
   output logic                    quarter_rate_clock_out,
   output cdr_pkg::demux_word_s    lane_word,
   output logic                    lane_valid,
   output logic                    demux_overrun,
   output logic                    acquire_overrun
);
   import cdr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic              ref_prev_ff;
   logic [DIV_W-1:0]  div_cnt_ff;
   logic [CNT_W-1:0]  ref_cnt_ff;
   logic [CNT_W-1:0]  osc_cnt_ff;
   logic              window_done_ff;
   logic              in_range_ff;
   logic [DIV_W-1:0]  nxt_div_cnt;
   logic [CNT_W-1:0]  nxt_ref_cnt;
   logic [CNT_W-1:0]  nxt_osc_cnt;
   logic              nxt_window_done;
   logic              nxt_in_range;
   logic              ref_edge;
   logic              osc_tick;
   logic [CNT_W-1:0]  osc_total;
   logic [CNT_W-1:0]  thresh;

   assign ref_edge = reference_clock_in & ~ref_prev_ff;
   assign osc_tick = vco_bit_tick && (div_cnt_ff == DIV_W'(REF_DIVIDE - 1));
   // Static select; a change mid-window only skews one comparison
   assign thresh   = threshold_coarse ? COARSE_THRESH : FINE_THRESH;

   always_comb begin
      osc_total       = (osc_tick && osc_cnt_ff != CNT_MAX) ?
                        12'(osc_cnt_ff + 12'h001) : osc_cnt_ff;
      nxt_div_cnt     = vco_bit_tick ? DIV_W'(div_cnt_ff + 1'b1)
                                     : div_cnt_ff;
      nxt_ref_cnt     = ref_cnt_ff;
      nxt_osc_cnt     = osc_total;
      nxt_window_done = 1'b0;
      nxt_in_range    = in_range_ff;
      if (ref_edge) begin
         if (ref_cnt_ff == WINDOW_LAST) begin
            nxt_window_done = 1'b1;
            nxt_in_range = abs_diff(osc_total, WINDOW_TARGET) <= thresh;
            nxt_ref_cnt  = '0;
            nxt_osc_cnt  = '0;
         end else begin
            nxt_ref_cnt = 12'(ref_cnt_ff + 12'h001);
         end
      end
      if (global_test_reset) begin
         nxt_div_cnt     = '0;
         nxt_ref_cnt     = '0;
         nxt_osc_cnt     = '0;
         nxt_window_done = 1'b0;
         nxt_in_range    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_prev_ff    <= 1'b0;
         div_cnt_ff     <= '0;
         ref_cnt_ff     <= '0;
         osc_cnt_ff     <= '0;
         window_done_ff <= 1'b0;
         in_range_ff    <= 1'b0;
      end else begin
         ref_prev_ff    <= reference_clock_in;
         div_cnt_ff     <= nxt_div_cnt;
         ref_cnt_ff     <= nxt_ref_cnt;
         osc_cnt_ff     <= nxt_osc_cnt;
         window_done_ff <= nxt_window_done;
         in_range_ff    <= nxt_in_range;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Loop mode. A good window first tries the bang-bang detector; only a
   // second good window confirms recovery, so lock toggles while pulling in.
   loop_mode_e        mode_ff;
   loop_mode_e        nxt_mode;
   logic              lock_ff;
   logic              nxt_lock;
   logic [31:0]       acq_cnt_ff;
   logic [31:0]       nxt_acq_cnt;
   logic              acq_over_ff;
   logic              nxt_acq_over;

   always_comb begin
      nxt_mode = mode_ff;
      if (window_done_ff) begin
         case (mode_ff)
            ACQ_PFD: if (in_range_ff) nxt_mode = ACQ_BB;
            ACQ_BB:  nxt_mode = in_range_ff ? TRACK : ACQ_PFD;
            TRACK:   if (!in_range_ff) nxt_mode = ACQ_PFD;
            default: nxt_mode = ACQ_PFD;
         endcase
      end
      if (global_test_reset) nxt_mode = ACQ_PFD;
      nxt_lock = (nxt_mode != ACQ_PFD);
      // Acquisition timer: flags an overrun of the acquisition budget
      if (nxt_mode == TRACK || global_test_reset) begin
         nxt_acq_cnt = '0;
      end else if (acq_cnt_ff < ACQ_LIMIT) begin
         nxt_acq_cnt = acq_cnt_ff + 32'h0000_0001;
      end else begin
         nxt_acq_cnt = acq_cnt_ff;
      end
      nxt_acq_over = (nxt_acq_cnt >= ACQ_LIMIT);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff     <= ACQ_PFD;
         lock_ff     <= 1'b0;
         acq_cnt_ff  <= '0;
         acq_over_ff <= 1'b0;
      end else begin
         mode_ff     <= nxt_mode;
         lock_ff     <= nxt_lock;
         acq_cnt_ff  <= nxt_acq_cnt;
         acq_over_ff <= nxt_acq_over;
      end
   end

   assign lock_indicator  = lock_ff;
   assign acquire_overrun = acq_over_ff;

   ////////////////////////////////////////////////////////////////////////
   // Detectors and pump
   logic              pfd_up_ff;
   logic              pfd_dn_ff;
   logic              prev_bit_ff;
   pump_e             pump_ff;
   logic              nxt_pfd_up;
   logic              nxt_pfd_dn;
   logic              nxt_prev_bit;
   pump_e             nxt_pump;
   logic              cur_bit;
   logic              bnd_bit;

   assign cur_bit = serial_in_pos & ~serial_in_neg;
   assign bnd_bit = boundary_in_pos & ~boundary_in_neg;

   always_comb begin
      nxt_pfd_up   = pfd_up_ff | ref_edge;
      nxt_pfd_dn   = pfd_dn_ff | osc_tick;
      if (nxt_pfd_up && nxt_pfd_dn) begin
         nxt_pfd_up = 1'b0;
         nxt_pfd_dn = 1'b0;
      end
      // Bit timing comes only from the tick, so any line rate in range works
      nxt_prev_bit = vco_bit_tick ? cur_bit : prev_bit_ff;
      nxt_pump     = PUMP_HIZ;
      if (mode_ff == ACQ_PFD) begin
         if (pfd_up_ff) nxt_pump = PUMP_SOURCE;
         else if (pfd_dn_ff) nxt_pump = PUMP_SINK;
      end else begin
         nxt_pfd_up = 1'b0;
         nxt_pfd_dn = 1'b0;
         if (vco_bit_tick && cur_bit != prev_bit_ff) begin
            // Boundary already shows the new bit: sampling is late
            nxt_pump = (bnd_bit == cur_bit) ? PUMP_SOURCE : PUMP_SINK;
         end
      end
      if (global_test_reset) begin
         nxt_pfd_up   = 1'b0;
         nxt_pfd_dn   = 1'b0;
         nxt_prev_bit = 1'b0;
         nxt_pump     = PUMP_HIZ;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pfd_up_ff   <= 1'b0;
         pfd_dn_ff   <= 1'b0;
         prev_bit_ff <= 1'b0;
         pump_ff     <= PUMP_HIZ;
      end else begin
         pfd_up_ff   <= nxt_pfd_up;
         pfd_dn_ff   <= nxt_pfd_dn;
         prev_bit_ff <= nxt_prev_bit;
         pump_ff     <= nxt_pump;
      end
   end

   assign pump_cmd = pump_ff;

   ////////////////////////////////////////////////////////////////////////
   // Demultiplexer. The line cannot be stalled, so a word that meets a full
   // buffer is dropped and flagged rather than held.
   logic [2:0]        shift_ff;
   logic [1:0]        bit_idx_ff;
   logic              qclk_ff;
   logic              push_valid_ff;
   demux_word_s       push_word_ff;
   logic              overrun_ff;
   logic [2:0]        nxt_shift;
   logic [1:0]        nxt_bit_idx;
   logic              nxt_qclk;
   logic              nxt_push_valid;
   demux_word_s       nxt_push_word;
   logic              nxt_overrun;
   logic              buf_in_ready;

   always_comb begin
      nxt_shift      = shift_ff;
      nxt_bit_idx    = bit_idx_ff;
      nxt_qclk       = qclk_ff;
      nxt_push_valid = 1'b0;
      nxt_push_word  = push_word_ff;
      nxt_overrun    = overrun_ff | (push_valid_ff & ~buf_in_ready);
      // Runs on the oscillator tick, so the clock keeps going without data
      if (vco_bit_tick) begin
         nxt_bit_idx = 2'(bit_idx_ff + 2'h1);
         nxt_qclk    = (nxt_bit_idx < CLK_HIGH_LANES);
         if (bit_idx_ff == LAST_LANE) begin
            nxt_push_valid = 1'b1;
            nxt_push_word  = '{parallel_lane_three: cur_bit,
                               parallel_lane_two:   shift_ff[2],
                               parallel_lane_one:   shift_ff[1],
                               parallel_lane_zero:  shift_ff[0]};
         end else begin
            // Only three bits wait; the fourth goes straight into the word
            nxt_shift[bit_idx_ff] = cur_bit;
         end
      end
      if (global_test_reset) begin
         nxt_shift      = '0;
         nxt_bit_idx    = '0;
         nxt_qclk       = 1'b0;
         nxt_push_valid = 1'b0;
         nxt_overrun    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_ff      <= '0;
         bit_idx_ff    <= '0;
         qclk_ff       <= 1'b0;
         push_valid_ff <= 1'b0;
         push_word_ff  <= '0;
         overrun_ff    <= 1'b0;
      end else begin
         shift_ff      <= nxt_shift;
         bit_idx_ff    <= nxt_bit_idx;
         qclk_ff       <= nxt_qclk;
         push_valid_ff <= nxt_push_valid;
         push_word_ff  <= nxt_push_word;
         overrun_ff    <= nxt_overrun;
      end
   end

   assign quarter_rate_clock_out = qclk_ff;
   assign demux_overrun          = overrun_ff;

   cdr_word_buffer u_buffer (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .clear     (global_test_reset),
      .in_valid  (push_valid_ff),
      .in_data   (push_word_ff),
      .in_ready  (buf_in_ready),
      .out_valid (lane_valid),
      .out_ready (lane_ready),
      .out_data  (lane_word)
   );

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   lock_in_track_a: assert property (
      mode_ff == TRACK |-> lock_indicator)
      else $error("lock low in recovery mode");
   lock_follows_det_a: assert property (
      lock_indicator == (mode_ff != ACQ_PFD))
      else $error("lock does not follow detector choice");
   range_loss_acq_a: assert property (
      window_done_ff && !in_range_ff && !global_test_reset
      |=> mode_ff == ACQ_PFD ##0 !lock_indicator)
      else $error("out of range window did not select acquisition");
   bb_confirm_track_a: assert property (
      mode_ff == ACQ_BB && window_done_ff && in_range_ff
      && !global_test_reset |=> mode_ff == TRACK)
      else $error("second good window did not enter recovery");
   pfd_cells_clear_a: assert property (
      !(pfd_up_ff && pfd_dn_ff)
      and ((mode_ff != ACQ_PFD && $past(mode_ff) != ACQ_PFD)
           |-> !pfd_up_ff && !pfd_dn_ff))
      else $error("frequency detector active outside acquisition");
   bb_late_source_a: assert property (
      mode_ff != ACQ_PFD && vco_bit_tick && cur_bit != prev_bit_ff
      && bnd_bit == cur_bit && !global_test_reset
      |=> pump_cmd == PUMP_SOURCE)
      else $error("late sample did not source current");
   bb_quiet_hiz_a: assert property (
      mode_ff != ACQ_PFD && (!vco_bit_tick || cur_bit == prev_bit_ff)
      |=> pump_cmd == PUMP_HIZ)
      else $error("pump driven without a transition");
   lane_order_a: assert property (
      vco_bit_tick && bit_idx_ff == LAST_LANE && !global_test_reset
      |=> push_valid_ff && push_word_ff.parallel_lane_three == $past(cur_bit)
          && push_word_ff.parallel_lane_zero == $past(shift_ff[0]))
      else $error("lane order wrong");
   qclk_low_half_a: assert property (
      vco_bit_tick && bit_idx_ff == 2'h1 && !global_test_reset
      |=> !quarter_rate_clock_out)
      else $error("quarter clock high in second half");
   test_reset_a: assert property (
      global_test_reset |=> mode_ff == ACQ_PFD && !lock_indicator
      && pump_cmd == PUMP_HIZ)
      else $error("test reset did not reset the loop");

   track_seen_c:   cover property (mode_ff == ACQ_BB ##1 mode_ff == TRACK);
   retry_seen_c:   cover property (mode_ff == ACQ_BB ##1 mode_ff == ACQ_PFD);
   overrun_seen_c: cover property ($rose(demux_overrun));
   stall_seen_c:   cover property (lane_valid && !lane_ready [*2]);

endmodule : cdr_lock_detect_demux

/* File: sim/cdr_line_model.sv */
`timescale 1ns/10ps
module cdr_line_model (
   input  wire logic ref_clk,
   input  wire logic run,
   input  wire logic tick_rand,
   output logic      reference_clock_in,
   output logic      vco_bit_tick,
   output logic      slow_ref,
   output int        ref_edges
);
   int phase;
   int period;

   initial begin
      reference_clock_in = 1'b0;
      slow_ref           = 1'b0;
      ref_edges          = 0;
      phase              = 0;
      period             = 2;
   end

   // Slow windows tick every cycle, so 64 ticks make one reference period
   assign vco_bit_tick = run & (slow_ref | tick_rand);

   ////////////////////////////////////////////////////////////////////////
   // Reference: fast outside edges 2000..3999 so those windows fail
   always @(negedge ref_clk) begin
      if (run) begin
         if (phase == 0) begin
            slow_ref = (ref_edges >= 2000) && (ref_edges < 4000);
            // A few long periods put the window near +2 counts
            period = !slow_ref ? 2 : ((ref_edges % 13 == 0) ? 65 : 64);
         end
         reference_clock_in = (phase >= period / 2);
         if (phase == period / 2) begin
            ref_edges++;
         end
         phase = (phase + 1 == period) ? 0 : phase + 1;
      end
   end
endmodule : cdr_line_model

/* File: sim/cdr_lock_detect_demux_tb.sv */
`timescale 1ns/10ps
module cdr_lock_detect_demux_tb;
   import cdr_pkg::*;

   localparam int unsigned ACQ_SMALL = 200;
   localparam int          CYC_LIMIT = 145000;

   logic        ref_clk           = 1'b0;
   logic        reset_n           = 1'b0;
   logic        global_test_reset = 1'b0;
   logic        threshold_coarse  = 1'b1;
   logic        serial_in_pos     = 1'b0;
   logic        serial_in_neg     = 1'b0;
   logic        boundary_in_pos   = 1'b0;
   logic        boundary_in_neg   = 1'b0;
   logic        lane_ready        = 1'b0;
   logic        run               = 1'b0;
   logic        tick_rand         = 1'b0;
   logic        quiet             = 1'b0;
   logic        hold_ready        = 1'b0;
   logic        ready_val         = 1'b1;
   logic        reference_clock_in;
   logic        vco_bit_tick;
   logic        slow_ref;
   int          ref_edges;
   logic        lock_indicator;
   pump_e       pump_cmd;
   logic        quarter_rate_clock_out;
   demux_word_s lane_word;
   logic        lane_valid;
   logic        demux_overrun;
   logic        acquire_overrun;
   int          seed = 6;
   int          failures = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          src_cnt = 0;
   int          push_cnt = 0;
   int          idx = 0;
   logic [31:0] rnd;
   logic        prev_bit = 1'b0;
   logic        cur_bit;
   logic        bnd_bit;
   logic        lock_q = 1'b0;
   pump_e       exp_pump = PUMP_HIZ;
   logic [3:0]  bits;
   demux_word_s exp_q[$];
   logic        qclk_hist[8];

   always #5 ref_clk = ~ref_clk;

   cdr_lock_detect_demux #(.ACQ_LIMIT(ACQ_SMALL)) uut (
      .ref_clk                (ref_clk),
      .reset_n                (reset_n),
      .global_test_reset      (global_test_reset),
      .threshold_coarse       (threshold_coarse),
      .reference_clock_in     (reference_clock_in),
      .vco_bit_tick           (vco_bit_tick),
      .serial_in_pos          (serial_in_pos),
      .serial_in_neg          (serial_in_neg),
      .boundary_in_pos        (boundary_in_pos),
      .boundary_in_neg        (boundary_in_neg),
      .lane_ready             (lane_ready),
      .lock_indicator         (lock_indicator),
      .pump_cmd               (pump_cmd),
      .quarter_rate_clock_out (quarter_rate_clock_out),
      .lane_word              (lane_word),
      .lane_valid             (lane_valid),
      .demux_overrun          (demux_overrun),
      .acquire_overrun        (acquire_overrun)
   );

   cdr_line_model line (
      .ref_clk            (ref_clk),
      .run                (run),
      .tick_rand          (tick_rand),
      .reference_clock_in (reference_clock_in),
      .vco_bit_tick       (vco_bit_tick),
      .slow_ref           (slow_ref),
      .ref_edges          (ref_edges)
   );

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   task automatic wait_edges(input int n);
      while (ref_edges < n) @(negedge ref_clk);
      repeat (5) @(negedge ref_clk);
   endtask : wait_edges

   ////////////////////////////////////////////////////////////////////////
   // Line data and downstream stalls; random stalls last at most 3 cycles, held ones while hold_ready is set
   always @(negedge ref_clk) begin
      rnd             = $random(seed);
      serial_in_pos   = rnd[0];
      serial_in_neg   = rnd[1] & rnd[2];
      boundary_in_pos = rnd[3];
      boundary_in_neg = rnd[4] & rnd[2];
      tick_rand       = rnd[5] & !quiet;
      lane_ready      = hold_ready ? ready_val : ((cyc % 7 < 4) | rnd[6]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Reference model: decision and demux, sampled before the edge lands
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == CYC_LIMIT) begin
         failures++;
         wrap_up();
      end else if (!reset_n || global_test_reset) begin
         exp_q.delete();
         idx      = 0;
         prev_bit = 1'b0;
         lock_q   = 1'b0;
         exp_pump = PUMP_HIZ;
      end else begin
         if (lock_q) chk({6'h0, pump_cmd}, {6'h0, exp_pump});
         if (!lock_q && pump_cmd === PUMP_SOURCE) src_cnt++;
         if (lane_valid === 1'b1 && lane_ready) begin
            if (exp_q.size() == 0) chk(8'h1, 8'h0);
            else chk({4'h0, lane_word}, {4'h0, exp_q.pop_front()});
         end
         exp_pump = PUMP_HIZ;
         if (vco_bit_tick) begin
            cur_bit = serial_in_pos & ~serial_in_neg;
            bnd_bit = boundary_in_pos & ~boundary_in_neg;
            if (cur_bit != prev_bit) begin
               exp_pump = (bnd_bit == cur_bit) ? PUMP_SOURCE : PUMP_SINK;
            end
            prev_bit  = cur_bit;
            bits[idx] = cur_bit;
            if (idx == 3) begin
               exp_q.push_back(demux_word_s'(bits));
               push_cnt++;
            end
            idx = (idx + 1) % 4;
         end
         lock_q = lock_indicator;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      run     = 1'b1;
      repeat (150) @(negedge ref_clk);
      chk({7'h0, acquire_overrun}, 8'h0);
      repeat (100) @(negedge ref_clk);
      chk({7'h0, acquire_overrun}, 8'h1);
      $display("test acquisition budget done");

      wait_edges(2000);
      chk({7'h0, lock_indicator}, 8'h0);
      chk({7'h0, src_cnt > 0}, 8'h1);
      $display("test fast reference window done");

      wait_edges(3000);
      chk({7'h0, lock_indicator}, 8'h0);
      for (int i = 0; i < 8; i++) begin
         qclk_hist[i] = quarter_rate_clock_out;
         @(negedge ref_clk);
      end
      for (int i = 0; i < 6; i++) begin
         chk({7'h0, qclk_hist[i] ^ qclk_hist[i + 2]}, 8'h1);
      end
      $display("test quarter rate clock done");

      wait_edges(4000);
      chk({7'h0, lock_indicator}, 8'h1);
      $display("test lock on good window done");

      wait_edges(6000);
      chk({7'h0, lock_indicator}, 8'h0);
      chk({7'h0, demux_overrun}, 8'h0);
      $display("test bang-bang window done");

      // Fill the buffer with the receiver stalled; the third word is lost
      quiet      = 1'b1;
      hold_ready = 1'b1;
      ready_val  = 1'b1;
      repeat (20) @(negedge ref_clk);
      ready_val = 1'b0;
      push_cnt  = 0;
      quiet     = 1'b0;
      while (push_cnt < 3) @(negedge ref_clk);
      quiet = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({7'h0, demux_overrun}, 8'h1);
      while (exp_q.size() > 2) exp_q.pop_back();
      ready_val = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk(8'(exp_q.size()), 8'h0);
      chk({7'h0, lane_valid}, 8'h0);
      $display("test buffer overflow done");

      global_test_reset = 1'b1;
      @(negedge ref_clk);
      global_test_reset = 1'b0;
      chk({7'h0, demux_overrun}, 8'h0);
      chk({7'h0, lock_indicator}, 8'h0);
      chk({6'h0, pump_cmd}, {6'h0, PUMP_HIZ});
      chk({7'h0, acquire_overrun}, 8'h0);
      $display("test global reset done");
      wrap_up();
   end
endmodule : cdr_lock_detect_demux_tb
